// [design/radio_tx_cfg.svh]
// Purpose : shared constants of the radio transmit interface
// Assumes : included by the package and by the design modules
// Notes   : definitions only
`ifndef RADIO_TX_CFG_SVH
`define RADIO_TX_CFG_SVH

// packet word layout from memory
`define TX_WORD_BITS   16
`define TX_MSB         15
`define TX_CNT_BITS    4
`define TX_LAST_BIT    4'hF
`define TX_FIRST_BIT   4'h0
`define TX_CNT_STEP    4'h1

// radio settings widths (power, frequency, rate)
`define TX_POWER_BITS  3
`define TX_FREQ_BITS   8
`define TX_RATE_BITS   2

// buffering and crossing
`define TX_FIFO_DEPTH  8
`define TX_SYNC_STAGES 3

// state encodings, gray along idle-load-send-done
`define TX_ST_IDLE     2'h0
`define TX_ST_LOAD     2'h1
`define TX_ST_SEND     2'h3
`define TX_ST_DONE     2'h2

`endif

// [design/radio_tx_pkg.sv]
// Purpose : types of the radio transmit interface
// Assumes : radio_tx_cfg.svh holds all numbers
// Notes   : nothing is imported; users write radio_tx_pkg::name
`include "radio_tx_cfg.svh"

package radio_tx_pkg;

  // one packet word as the dma channel delivers it
  typedef struct packed {
    logic                     last;  // final word of the packet
    logic [`TX_WORD_BITS-1:0] data;  // sent msb first
  } tx_word_type;

  // settings handed to the radio with the request
  typedef struct packed {
    logic [`TX_POWER_BITS-1:0] power;
    logic [`TX_FREQ_BITS-1:0]  freq;
    logic [`TX_RATE_BITS-1:0]  rate;
  } radio_ctrl_type;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = `TX_ST_IDLE,
    ST_LOAD = `TX_ST_LOAD,
    ST_SEND = `TX_ST_SEND,
    ST_DONE = `TX_ST_DONE
  } tx_state_type;

  // whole core-domain state of the interface
  typedef struct packed {
    tx_state_type                state;
    logic [`TX_WORD_BITS-1:0]    shift;     // msb is the next bit out
    logic [`TX_CNT_BITS-1:0]     bitCnt;    // bit index inside the word
    logic                        last;      // word in shift ends packet
    radio_ctrl_type              held;      // settings loaded by software
    radio_ctrl_type              shown;     // settings on the radio pins
    logic                        req;       // send request to the radio
    logic                        underrun;  // memory fell behind
    logic [`TX_SYNC_STAGES-1:0]  clkSync;   // bit clock synchroniser
    logic                        clkStable; // filtered bit clock level
    logic                        linkClr;   // holds link flop cleared
  } core_state_type;

endpackage

// [design/tx_word_fifo.sv]
// Purpose : word buffer between the dma channel and the serialiser
// Assumes : DEPTH is a power of two; single clock
// Notes   : read data leave a register; one extra word sits there
`include "radio_tx_cfg.svh"

module tx_word_fifo #(
  parameter int WIDTH = `TX_WORD_BITS + 1,
  parameter int DEPTH = `TX_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // filling side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // draining side
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  localparam int PB = $clog2(DEPTH);  // pointer width
  localparam int CB = PB + 1;         // count width

  // all state except the storage array
  typedef struct packed {
    logic [PB-1:0]    wrPtr;
    logic [PB-1:0]    rdPtr;
    logic [CB-1:0]    count;
    logic [WIDTH-1:0] outData;
    logic             outValid;
  } fifo_state_type;

  fifo_state_type           s_q;     // registered state
  fifo_state_type           s_d;     // next state
  logic [WIDTH-1:0]         mem [DEPTH];  // storage
  logic                     push;    // word accepted
  logic                     refill;  // output stage loads from storage

  // full is honest: no push while every slot holds a word
  assign inReady  = (s_q.count != CB'(DEPTH));
  assign outValid = s_q.outValid;
  assign outData  = s_q.outData;
  assign push     = inValid & inReady;

  // refill when the output register empties or is taken this cycle
  assign refill = (s_q.count != '0) & (~s_q.outValid | outReady);

  // next-state logic
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wrPtr = s_q.wrPtr + PB'(1);
    end
    if (refill) begin
      s_d.outData  = mem[s_q.rdPtr];
      s_d.outValid = 1'b1;
      s_d.rdPtr    = s_q.rdPtr + PB'(1);
    end else if (outReady) begin
      s_d.outValid = 1'b0;  // taken with nothing behind it
    end
    // storage occupancy moves by push minus refill
    if (push & ~refill) begin
      s_d.count = s_q.count + CB'(1);
    end else if (~push & refill) begin
      s_d.count = s_q.count - CB'(1);
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // storage write, no reset needed on data
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[s_q.wrPtr] <= inData;
    end
  end

endmodule

// [design/radio_transmit_interface.sv]
// Purpose : transmit side of the radio interface: settings, request,
//           serial data paced by the bit clock the radio returns
// Assumes : bit clock stops outside packets; dma words end with last
// Notes   : the bit clock is also sampled into core_clk for pacing
// Behaviour
// - keep power, frequency, rate settings loaded
// - settings stand on pins when request rises
// - each bit clock edge takes one bit
// - send every packet word, nothing added; an empty buffer at a word boundary ends the packet early, flagged as underrun
// - drop request after the final bit
// - no fixed wait for the bit clock
// - finish a word before taking the next
`include "radio_tx_cfg.svh"

module radio_transmit_interface #(
  parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // processor side
  input  radio_tx_pkg::radio_ctrl_type     ctrlIn,
  input  wire logic                        ctrlLoad,
  input  wire logic                        startSend,
  output logic                             busy,
  output logic                             underrun,
  // dma channel side
  input  radio_tx_pkg::tx_word_type        dmaWord,
  input  wire logic                        dmaValid,
  output logic                             dmaReady,
  // radio link
  input  wire logic                        bitClk,
  output logic                             sendRequest,
  output radio_tx_pkg::radio_ctrl_type     radioCtrl,
  output logic                             txData
);

  radio_tx_pkg::core_state_type s_q;      // registered state
  radio_tx_pkg::core_state_type s_d;      // next state
  radio_tx_pkg::tx_word_type    fifoWord; // head of the buffer
  logic                         fifoValid;  // head holds a word
  logic                         fifoPop;    // serialiser takes head
  logic                         bitRise;    // filtered bit clock edge
  logic                         wordEnd;    // last bit of word taken
  logic                         linkBit_q;  // data flop on the link

  // buffer between memory fetches and the bit stream
  tx_word_fifo #(
    .WIDTH ($bits(radio_tx_pkg::tx_word_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .rst      (rst),
    .inData   (dmaWord),
    .inValid  (dmaValid),
    .inReady  (dmaReady),
    .outData  (fifoWord),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  // a rising edge counts once stages two and three agree on high
  assign bitRise = ~s_q.clkStable & s_q.clkSync[1] & s_q.clkSync[2];

  // the edge just seen took the word's final bit
  assign wordEnd = bitRise & (s_q.bitCnt == `TX_LAST_BIT);

  // head is taken at the first load and at each word boundary
  always_comb begin
    fifoPop = 1'b0;
    case (s_q.state)
      radio_tx_pkg::ST_LOAD: begin
        fifoPop = fifoValid;
      end
      radio_tx_pkg::ST_SEND: begin
        fifoPop = wordEnd & ~s_q.last & fifoValid;
      end
      default: begin
        fifoPop = 1'b0;
      end
    endcase
  end

  // sequencer and serialiser, one process for the whole state
  always_comb begin
    s_d = s_q;
    // three-stage synchroniser; stage one feeds stage two only
    s_d.clkSync = {s_q.clkSync[1:0], bitClk};
    // level changes only when stages two and three agree
    if (s_q.clkSync[1] == s_q.clkSync[2]) begin
      s_d.clkStable = s_q.clkSync[2];
    end
    // software may reload the settings at any time
    if (ctrlLoad) begin
      s_d.held = ctrlIn;
    end
    case (s_q.state)
      radio_tx_pkg::ST_IDLE: begin
        s_d.linkClr = 1'b1;
        if (startSend) begin
          // settings go to the pins ahead of the request
          s_d.shown    = s_q.held;
          s_d.underrun = 1'b0;
          s_d.linkClr  = 1'b0;
          s_d.state    = radio_tx_pkg::ST_LOAD;
        end
      end
      radio_tx_pkg::ST_LOAD: begin
        // request rises only once the first word is in hand
        if (fifoValid) begin
          s_d.shift  = fifoWord.data;
          s_d.last   = fifoWord.last;
          s_d.bitCnt = `TX_FIRST_BIT;
          s_d.req    = 1'b1;
          s_d.state  = radio_tx_pkg::ST_SEND;
        end
      end
      radio_tx_pkg::ST_SEND: begin
        // pacing comes only from returned edges, never a timer
        if (wordEnd) begin
          if (s_q.last) begin
            s_d.req   = 1'b0;
            s_d.state = radio_tx_pkg::ST_DONE;
          end else if (fifoValid) begin
            s_d.shift  = fifoWord.data;
            s_d.last   = fifoWord.last;
            s_d.bitCnt = `TX_FIRST_BIT;
          end else begin
            // memory fell behind: abandon rather than send junk
            s_d.underrun = 1'b1;
            s_d.req      = 1'b0;
            s_d.state    = radio_tx_pkg::ST_DONE;
          end
        end else if (bitRise) begin
          // next bit moves to the msb, msb first on the line
          s_d.shift  = {s_q.shift[`TX_MSB-1:0], 1'b0};
          s_d.bitCnt = s_q.bitCnt + `TX_CNT_STEP;
        end
      end
      radio_tx_pkg::ST_DONE: begin
        // radio may still clock out its own buffer; we are finished
        s_d.shift   = '0;
        s_d.linkClr = 1'b1;
        s_d.state   = radio_tx_pkg::ST_IDLE;
      end
      default: begin
        s_d.state = radio_tx_pkg::ST_IDLE;
      end
    endcase
  end

  // core-domain state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q         <= '0;
      s_q.linkClr <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // link-domain data flop. the core updates shift msb only just after
  // it sees an edge, so the value is settled long before the next one.
  // the clear is released before the request rises, hence before any
  // bit clock edge of the packet.
  always_ff @(posedge bitClk or posedge s_q.linkClr) begin
    if (s_q.linkClr) begin
      linkBit_q <= 1'b0;
    end else begin
      linkBit_q <= s_q.shift[`TX_MSB];
    end
  end

  // outputs
  assign sendRequest = s_q.req;
  assign radioCtrl   = s_q.shown;
  assign txData      = linkBit_q;
  assign underrun    = s_q.underrun;
  assign busy        = (s_q.state != radio_tx_pkg::ST_IDLE);

  // checks on the core clock

  // software load lands in the held settings next cycle
  property p_ctrlHeld;
    @(posedge core_clk) disable iff (rst)
      ctrlLoad |=> (s_q.held == $past(ctrlIn));
  endproperty
  a_ctrlHeld: assert property (p_ctrlHeld)
    else $error("loaded settings not held");

  // settings already stood a cycle when the request rises
  property p_ctrlAtRise;
    @(posedge core_clk) disable iff (rst)
      $rose(sendRequest) |-> $stable(radioCtrl);
  endproperty
  a_ctrlAtRise: assert property (p_ctrlAtRise)
    else $error("settings changed with request rise");

  // settings stay put while the request is high
  property p_ctrlSteady;
    @(posedge core_clk) disable iff (rst)
      sendRequest && $past(sendRequest) |-> $stable(radioCtrl);
  endproperty
  a_ctrlSteady: assert property (p_ctrlSteady)
    else $error("settings moved during packet");

  // each edge inside a word advances the index by exactly one
  property p_bitStep;
    @(posedge core_clk) disable iff (rst)
      (s_q.state == radio_tx_pkg::ST_SEND) && bitRise && !wordEnd
      |=> (s_q.bitCnt == $past(s_q.bitCnt) + `TX_CNT_STEP);
  endproperty
  a_bitStep: assert property (p_bitStep)
    else $error("bit index did not step on edge");

  // without an edge nothing advances, whatever the time spent
  property p_noTimer;
    @(posedge core_clk) disable iff (rst)
      (s_q.state == radio_tx_pkg::ST_SEND) && !bitRise
      |=> $stable(s_q.bitCnt) && $stable(s_q.shift) && sendRequest;
  endproperty
  a_noTimer: assert property (p_noTimer)
    else $error("serialiser moved without a bit clock edge");

  // at a boundary the next word loads whole, msb first, index zero
  property p_wordLoad;
    @(posedge core_clk) disable iff (rst)
      (s_q.state == radio_tx_pkg::ST_SEND) && fifoPop
      |=> (s_q.shift == $past(fifoWord.data))
          && (s_q.bitCnt == `TX_FIRST_BIT);
  endproperty
  a_wordLoad: assert property (p_wordLoad)
    else $error("next word not loaded at boundary");

  // a word is never fetched before its sixteenth bit went out
  property p_wordWhole;
    @(posedge core_clk) disable iff (rst)
      (s_q.state == radio_tx_pkg::ST_SEND) && fifoPop
      |-> (s_q.bitCnt == `TX_LAST_BIT) && bitRise;
  endproperty
  a_wordWhole: assert property (p_wordWhole)
    else $error("word fetched before it was fully sent");

  // request falls right after the last bit of the last word
  property p_reqDrop;
    @(posedge core_clk) disable iff (rst)
      (s_q.state == radio_tx_pkg::ST_SEND) && wordEnd && s_q.last
      |=> !sendRequest ##1 !busy;
  endproperty
  a_reqDrop: assert property (p_reqDrop)
    else $error("request not dropped after final bit");

  // filtered level follows the bit clock only when stages agree
  property p_syncAgree;
    @(posedge core_clk) disable iff (rst)
      (s_q.clkSync[1] != s_q.clkSync[2]) |=> $stable(s_q.clkStable);
  endproperty
  a_syncAgree: assert property (p_syncAgree)
    else $error("bit clock level changed before stages agreed");

  // a held bit clock level reaches the filter within four cycles
  property p_syncReach;
    @(posedge core_clk) disable iff (rst)
      bitClk [*4] |-> ##[0:1] s_q.clkStable;
  endproperty
  a_syncReach: assert property (p_syncReach)
    else $error("steady bit clock not seen by the filter");

  // a start from idle shows the held settings and turns busy
  property p_startShow;
    @(posedge core_clk) disable iff (rst)
      (s_q.state == radio_tx_pkg::ST_IDLE) && startSend
      |=> busy && (radioCtrl == $past(s_q.held));
  endproperty
  a_startShow: assert property (p_startShow)
    else $error("settings not shown on start");

  // inside a word the next bit moves up to the msb
  property p_msbFirst;
    @(posedge core_clk) disable iff (rst)
      (s_q.state == radio_tx_pkg::ST_SEND) && bitRise && !wordEnd
      |=> (s_q.shift == {$past(s_q.shift[`TX_MSB-1:0]), 1'b0});
  endproperty
  a_msbFirst: assert property (p_msbFirst)
    else $error("shift did not move msb first");

  // nothing is fetched once the final word is in the shifter
  property p_lastNoFetch;
    @(posedge core_clk) disable iff (rst)
      (s_q.state == radio_tx_pkg::ST_SEND) && s_q.last |-> !fifoPop;
  endproperty
  a_lastNoFetch: assert property (p_lastNoFetch)
    else $error("word fetched beyond the final word");

  // an empty buffer at a boundary ends the packet, flagged, so the
  // radio never sends stale bits as if they were packet data
  property p_underrunStop;
    @(posedge core_clk) disable iff (rst)
      (s_q.state == radio_tx_pkg::ST_SEND) && wordEnd && !s_q.last && !fifoValid
      |=> !sendRequest && underrun;
  endproperty
  a_underrunStop: assert property (p_underrunStop)
    else $error("missing word did not end the packet");

  // idle means no request and a cleared data line
  property p_idleQuiet;
    @(posedge core_clk) disable iff (rst)
      (s_q.state == radio_tx_pkg::ST_IDLE) |-> !sendRequest && !txData;
  endproperty
  a_idleQuiet: assert property (p_idleQuiet)
    else $error("request or data active while idle");

endmodule

// [verification/radio_model.sv]
// Purpose : radio modem that answers the send request with a bit clock
// Assumes : settings are valid on the pins when the request rises
// Notes   : the bit clock stands low between packets; period 64 ns
module radio_model (
  // link pins
  output logic                         bitClk,
  input  wire logic                    sendRequest,
  input  radio_tx_pkg::radio_ctrl_type radioCtrl,
  input  wire logic                    txData,
  // bench knob: preparation time in ns
  input  wire logic [15:0]             prepNs
);
  timeunit 1ns;
  timeprecision 100ps;

  radio_tx_pkg::radio_ctrl_type ctrlSeen; // settings taken with the request
  logic                         bits[$];  // bits in the order the radio took them
  int                           glitches; // data moved inside a bit period
  logic                         early;    // data seen just after the rising edge

  // clock idles low so no stray edge reaches the interface
  initial begin
    bitClk   = 1'b0;
    glitches = 0;
  end

  // prepare, then clock bits until the request has gone
  always @(posedge sendRequest) begin
    ctrlSeen = radioCtrl;
    #(prepNs);
    while (sendRequest === 1'b1) begin
      bitClk = 1'b1;
      #6 early = txData;
      // sample at mid period, as the clock falls, after the data settled
      #26 bits.push_back(txData);
      bitClk = 1'b0;
      // only a bit period that ends in another edge must keep its data;
      // once the request is gone the interface clears the line on purpose
      #31 if (txData !== early && sendRequest === 1'b1) glitches++;
      #1;
    end
  end
endmodule

// [verification/test_radio_transmit_interface.sv]
// Purpose : self-checking bench of the radio transmit interface
// Assumes : radio_model clocks bits and records them
// Notes   : a long preparation time doubles as a stall of the far side
module test_radio_transmit_interface;
  timeunit 1ns;
  timeprecision 100ps;

  logic                         core_clk, rst, ctrlLoad, startSend, dmaValid;
  logic                         bitClk, busy, underrun, dmaReady, sendRequest, txData;
  radio_tx_pkg::radio_ctrl_type ctrlIn, radioCtrl;
  radio_tx_pkg::tx_word_type    dmaWord;
  logic [15:0]                  prepNs;     // radio preparation time
  int                           miscompares;
  int                           n_checks;
  logic [15:0]                  sent[$];    // words expected on the wire

  radio_transmit_interface #(.FIFO_DEPTH(8)) i_radio_transmit_interface (
    .core_clk(core_clk), .rst(rst), .ctrlIn(ctrlIn), .ctrlLoad(ctrlLoad),
    .startSend(startSend), .busy(busy), .underrun(underrun), .dmaWord(dmaWord),
    .dmaValid(dmaValid), .dmaReady(dmaReady), .bitClk(bitClk),
    .sendRequest(sendRequest), .radioCtrl(radioCtrl), .txData(txData));

  radio_model i_radio_model (.bitClk(bitClk), .sendRequest(sendRequest),
    .radioCtrl(radioCtrl), .txData(txData), .prepNs(prepNs));

  // core clock, 10 ns
  always #5 core_clk = ~core_clk;

  // one place for every comparison
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // inputs move 1 ns after the edge
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // offer a word and hold it until taken; valid stays up for back to back
  task put(input logic last, input logic [15:0] data);
    int t;
    t = 0;
    dmaWord  = {last, data};
    dmaValid = 1'b1;
    while (dmaReady !== 1'b1 && t < 5000) begin
      tick(1);
      t++;
    end
    tick(1);
    sent.push_back(data);
  endtask

  task load(input radio_tx_pkg::radio_ctrl_type c);
    ctrlIn   = c;
    ctrlLoad = 1'b1;
    tick(1);
    ctrlLoad = 1'b0;
  endtask

  task start;
    startSend = 1'b1;
    tick(1);
    startSend = 1'b0;
  endtask

  // bounded wait for the end of a packet
  task wait_idle;
    int t;
    t = 0;
    while (busy !== 1'b0 && t < 40000) begin
      tick(1);
      t++;
    end
    check("idle reached", t < 40000, 1);
  endtask

  // compare the radio's bits with the words, msb first, no gaps
  task check_bits;
    int i;
    check("bit count", i_radio_model.bits.size(), sent.size() * 16);
    for (i = 0; i < sent.size() * 16 && i < i_radio_model.bits.size(); i++)
      check("bit", i_radio_model.bits[i], sent[i / 16][15 - i % 16]);
    check("data steady", i_radio_model.glitches, 0);
    sent.delete();
    i_radio_model.bits.delete();
  endtask

  task t_reset;
    check("busy", busy, 0);
    check("sendRequest", sendRequest, 0);
    check("radioCtrl", radioCtrl, 0);
    check("underrun", underrun, 0);
    check("txData", txData, 0);
    check("dmaReady", dmaReady, 1);
  endtask

  // preloaded packet; a second start and a new load arrive mid-packet
  task t_packet;
    load({3'h5, 8'hA3, 2'h2});
    put(1'b0, 16'hAAAA);
    put(1'b0, 16'h1234);
    put(1'b1, 16'h8001);
    dmaValid = 1'b0;
    start;
    tick(1);
    check("radioCtrl", radioCtrl, {3'h5, 8'hA3, 2'h2});
    load({3'h2, 8'h5C, 2'h1});
    start;
    wait_idle;
    check("ctrl at radio", i_radio_model.ctrlSeen, {3'h5, 8'hA3, 2'h2});
    check("sendRequest", sendRequest, 0);
    check_bits;
    tick(5);
    check("busy after ignored start", busy, 0);
  endtask

  // fill the buffer until it refuses, then drain behind a slow radio
  task t_fill;
    int i;
    prepNs = 16'h0BB8;
    for (i = 0; i < 9; i++)
      put(i == 8, 16'h0F00 ^ 16'(i * 16'h1111));
    dmaValid = 1'b0;
    check("dmaReady full", dmaReady, 0);
    start;
    tick(1);
    check("radioCtrl", radioCtrl, {3'h2, 8'h5C, 2'h1});
    wait_idle;
    check("ctrl at radio", i_radio_model.ctrlSeen, {3'h2, 8'h5C, 2'h1});
    check_bits;
    prepNs = 16'h00C8;
  endtask

  // memory falls behind, then the next start clears the flag
  task t_under;
    put(1'b0, 16'hC3C3);
    dmaValid = 1'b0;
    start;
    wait_idle;
    check("underrun", underrun, 1);
    check("sendRequest", sendRequest, 0);
    sent.delete();
    i_radio_model.bits.delete();
    put(1'b1, 16'h5A5A);
    dmaValid = 1'b0;
    start;
    tick(1);
    check("underrun cleared", underrun, 0);
    wait_idle;
    check_bits;
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // main sequence
  initial begin
    core_clk    = 1'b0;
    rst         = 1'b1;
    ctrlIn      = '0;
    ctrlLoad    = 1'b0;
    startSend   = 1'b0;
    dmaWord     = '0;
    dmaValid    = 1'b0;
    prepNs      = 16'h00C8;
    miscompares = 0;
    n_checks    = 0;
    tick(20);
    rst = 1'b0;
    tick(2);
    t_reset;
    t_packet;
    t_fill;
    t_under;
    stop_test;
  end

  // cut a hang short; the whole run needs about 18 us
  initial begin
    #200000;
    miscompares++;
    stop_test;
  end
endmodule
